/* File: pad_board.sv */
// Board model: pad wires with pull-ups and external drivers
`timescale 1ns/1ns
`default_nettype none
module pad_board (
    // Drive from the port
    input wire port_two_pkg::pad_drive_t pad_out,
    // External drivers
    input wire logic [7:0] ext_level,
    input wire logic [7:0] ext_oe,
    // Resolved wire levels
    output logic [7:0] pad_in
);
    // Port drive wins; a released wire floats up to its pull-up, never holds old data
    assign pad_in = (pad_out.oe & pad_out.level) | (~pad_out.oe & ~(ext_oe & ~ext_level));
endmodule : pad_board
`default_nettype wire

/* File: pin_sync.sv */
// Two-stage synchroniser for the port-two pad inputs
`timescale 1ns/1ns
`default_nettype none

module pin_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Asynchronous pad levels
    input wire logic [port_two_pkg::PIN_COUNT-1:0] pad_async,
    // Levels safe to use in the clock domain
    output logic [port_two_pkg::PIN_COUNT-1:0] pad_synced
);

    // First stage is read by the second stage only
    logic [port_two_pkg::PIN_COUNT-1:0] meta;

    // Both stages clear to zero, pads are unknown at reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            pad_synced <= '0;
        end else begin
            meta <= pad_async;
            pad_synced <= meta;
        end
    end

endmodule : pin_sync

`default_nettype wire

/* File: port_two_gpio.sv */
// Port-two GPIO block: registers on AHB-Lite, pad drive and serial pin sharing
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Output pins read back the data latch, not the pad level.
// - Input pins read back the synchronised pad level.
// - Reset clears the data latch to all zeros.
// - Direction bit one makes the pin an output, zero an input.
// - Direction and latch only steer pins left in plain I/O use.
// - Direction register is write-only and reads as all ones.
// - Reset clears every direction bit, all pins start as inputs.
// - Function select bits 7,6,4,3 read one, ignore writes; resets to D8.
// - Function bit 5 makes the serial output pin open-drain.
// - Function bit 2 hands pin 2 to the serial output.
// - Function bit 1 hands pin 1 to the serial input.
// - Function bit 0 hands pin 0 to the bidirectional serial clock.
// - Per-pin open-drain bit picks push-pull or open-drain output drive for pins in plain I/O use.
// - Reset clears all open-drain bits, outputs start push-pull.
// - Pins 7 to 3 follow their own direction bit only.
module port_two_gpio (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Pads
    input wire logic [7:0] pad_in,
    output port_two_pkg::pad_drive_t pad_out,
    // Serial interface
    input wire port_two_pkg::serial_drive_t serial_drive,
    output port_two_pkg::serial_sense_t serial_sense
);

    // Register decode of a captured address phase against one index
    function automatic logic reg_hit(
        input port_two_pkg::addr_phase_t ph,
        input logic [29:0] idx
    );
        reg_hit = ph.valid && (ph.word == idx);
    endfunction : reg_hit

    // Registers
    logic [7:0] function_select;
    logic [7:0] open_drain_select;
    logic [7:0] data_latch;
    logic [7:0] direction;

    // Bus state
    port_two_pkg::addr_phase_t addr_ph;
    port_two_pkg::addr_phase_t next_addr_ph;

    // Synchronised pads
    logic [7:0] pad_level;

    // Per-pin drive intent
    logic [7:0] alt_on;
    logic [7:0] want_drive;
    logic [7:0] want_level;
    logic [7:0] want_od;
    logic [7:0] next_level;
    logic [7:0] next_oe;

    // Pad inputs come from outside the clock domain
    pin_sync u_pin_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pad_async(pad_in),
        .pad_synced(pad_level)
    );

    // -----------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // -----------------------------------------------------------------

    // Address phase is taken only while the bus is ready
    wire trans_active = (htrans == port_two_pkg::HTRANS_NONSEQ) ||
                        (htrans == port_two_pkg::HTRANS_SEQ);
    wire take_addr = hsel && trans_active && hready;

    // Capture enough of the address phase for the data phase
    always_comb begin
        next_addr_ph = addr_ph;
        if (hready) begin
            next_addr_ph.valid = take_addr;
            next_addr_ph.write = hwrite;
            next_addr_ph.word = haddr[31:2];
        end
    end

    // Bus state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_ph <= '0;
        end else begin
            addr_ph <= next_addr_ph;
        end
    end

    // Write strobes, one per register, in the data phase
    wire wr_phase = addr_ph.valid && addr_ph.write && hready;
    wire wr_func = wr_phase && reg_hit(addr_ph, port_two_pkg::IDX_FUNCTION_SELECT);
    wire wr_od = wr_phase && reg_hit(addr_ph, port_two_pkg::IDX_OPEN_DRAIN_SELECT);
    wire wr_data = wr_phase && reg_hit(addr_ph, port_two_pkg::IDX_DATA_LATCH);
    wire wr_dir = wr_phase && reg_hit(addr_ph, port_two_pkg::IDX_DIRECTION);

    // Only the low byte lane carries register data; hsize is single words only
    wire [7:0] wr_byte = hwdata[7:0];

    // Reserved function bits are forced back to one on every write
    wire [7:0] func_written = (wr_byte & port_two_pkg::FUNC_WRITABLE) |
                              port_two_pkg::FUNC_RESERVED_ONES;

    // -----------------------------------------------------------------
    // Register file
    // -----------------------------------------------------------------

    // Function select and open-drain select
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            function_select <= port_two_pkg::RST_FUNCTION_SELECT;
            open_drain_select <= port_two_pkg::RST_OPEN_DRAIN_SELECT;
        end else begin
            if (wr_func) begin
                function_select <= func_written;
            end
            if (wr_od) begin
                open_drain_select <= wr_byte;
            end
        end
    end

    // Data latch and direction
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_latch <= port_two_pkg::RST_DATA_LATCH;
            direction <= port_two_pkg::RST_DIRECTION;
        end else begin
            if (wr_data) begin
                data_latch <= wr_byte;
            end
            if (wr_dir) begin
                direction <= wr_byte;
            end
        end
    end

    // -----------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------

    // Outputs show the latch, inputs show the pad, bit by bit
    wire [7:0] data_readback = (direction & data_latch) |
                               (~direction & pad_level);

    // Read mux is combinational on the registered phase, so a read
    // right after a write already sees the new value
    wire rd_func = reg_hit(addr_ph, port_two_pkg::IDX_FUNCTION_SELECT);
    wire rd_od = reg_hit(addr_ph, port_two_pkg::IDX_OPEN_DRAIN_SELECT);
    wire rd_data = reg_hit(addr_ph, port_two_pkg::IDX_DATA_LATCH);
    wire rd_dir = reg_hit(addr_ph, port_two_pkg::IDX_DIRECTION);
    wire rd_any = !addr_ph.write;

    // Unmapped reads return zero
    wire [7:0] rd_byte =
        !rd_any ? 8'h00 :
        rd_func ? (function_select | port_two_pkg::FUNC_RESERVED_ONES) :
        rd_od ? open_drain_select :
        rd_data ? data_readback :
        rd_dir ? port_two_pkg::DIRECTION_READ_VALUE :
        8'h00;

    // Upper lanes read as zero
    assign hrdata = {{(port_two_pkg::BUS_WIDTH - 8){1'b0}}, rd_byte};
    assign hreadyout = 1'b1;
    assign hresp = port_two_pkg::HRESP_OKAY;

    // -----------------------------------------------------------------
    // Pin function selection
    // -----------------------------------------------------------------

    // Function bits per pin; pins 7 to 3 have no alternate use
    wire so_sel = function_select[port_two_pkg::BIT_SERIAL_OUT_PIN_SELECT];
    wire si_sel = function_select[port_two_pkg::BIT_SERIAL_IN_PIN_SELECT];
    wire sck_sel = function_select[port_two_pkg::BIT_SERIAL_CLOCK_PIN_SELECT];
    wire so_pmos_off = function_select[port_two_pkg::BIT_SERIAL_OUT_PMOS_OFF];

    // Pin-indexed view of the alternate selects
    always_comb begin
        alt_on = '0;
        alt_on[port_two_pkg::PIN_SERIAL_OUT] = so_sel;
        alt_on[port_two_pkg::PIN_SERIAL_IN] = si_sel;
        alt_on[port_two_pkg::PIN_SERIAL_CLOCK] = sck_sel;
    end

    // Intent per pin: plain I/O unless an alternate function owns it
    genvar n;
    generate
        for (n = 0; n < port_two_pkg::PIN_COUNT; n++) begin : g_pin
            if (n == port_two_pkg::PIN_SERIAL_OUT) begin : g_so
                // Serial output drives always; its buffer type is separate
                assign want_drive[n] = alt_on[n] ? 1'b1 : direction[n];
                assign want_level[n] = alt_on[n] ? serial_drive.data_out : data_latch[n];
                assign want_od[n] = alt_on[n] ? so_pmos_off : open_drain_select[n];
            end else if (n == port_two_pkg::PIN_SERIAL_IN) begin : g_si
                // Serial input never drives the pad
                assign want_drive[n] = alt_on[n] ? 1'b0 : direction[n];
                assign want_level[n] = data_latch[n];
                assign want_od[n] = open_drain_select[n];
            end else if (n == port_two_pkg::PIN_SERIAL_CLOCK) begin : g_sck
                // Serial interface decides clock direction itself
                assign want_drive[n] = alt_on[n] ? serial_drive.clock_oe : direction[n];
                assign want_level[n] = alt_on[n] ? serial_drive.clock_out : data_latch[n];
                assign want_od[n] = alt_on[n] ? 1'b0 : open_drain_select[n];
            end else begin : g_plain
                // Plain pins obey their own direction bit
                assign want_drive[n] = direction[n];
                assign want_level[n] = data_latch[n];
                assign want_od[n] = open_drain_select[n];
            end

            // Open-drain pulls low only; a high level releases the pad
            assign next_level[n] = want_od[n] ? 1'b0 : want_level[n];
            assign next_oe[n] = want_drive[n] && (!want_od[n] || !want_level[n]);
        end
    endgenerate

    // Pad drive from flip-flops; one cycle behind the registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= '0;
        end else begin
            pad_out.level <= next_level;
            pad_out.oe <= next_oe;
        end
    end

    // -----------------------------------------------------------------
    // Serial interface sense
    // -----------------------------------------------------------------

    // Only meaningful when the pin is handed over; masked otherwise so the
    // serial block sees a quiet line while the pin serves as plain I/O
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            serial_sense <= '0;
        end else begin
            serial_sense.data_in <= si_sel & pad_level[port_two_pkg::PIN_SERIAL_IN];
            serial_sense.clock_in <= sck_sel & pad_level[port_two_pkg::PIN_SERIAL_CLOCK];
        end
    end

endmodule : port_two_gpio

`default_nettype wire

/* File: port_two_gpio_sva.sv */
// Checker for the port-two GPIO block, fed from its ports only
`timescale 1ns/1ns
`default_nettype none
module port_two_gpio_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Pads and serial side
    input wire port_two_pkg::pad_drive_t pad_out,
    input wire port_two_pkg::serial_drive_t serial_drive
);
    logic ph_wr;
    logic [29:0] ph_idx;
    logic [7:0] fs, od, lat, dir;
    // Read address phases taken at this edge, by register
    wire [29:0] ai = haddr[31:2];
    wire rd_take = hsel && htrans[1] && hready && !hwrite;
    wire rd_dir = rd_take && ai == port_two_pkg::IDX_DIRECTION;
    wire rd_fs = rd_take && ai == port_two_pkg::IDX_FUNCTION_SELECT;
    wire rd_lat = rd_take && ai == port_two_pkg::IDX_DATA_LATCH;
    wire [7:0] wd = hwdata[7:0];
    // Shadow registers from observed writes; data phase is always one cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {ph_wr, ph_idx, od, lat, dir} <= 55'h0;
            fs <= 8'hD8;
        end else begin
            ph_wr <= hsel && htrans[1] && hready && hwrite;
            ph_idx <= ai;
            if (ph_wr && ph_idx == port_two_pkg::IDX_FUNCTION_SELECT) fs <= (wd & 8'h27) | 8'hD8;
            if (ph_wr && ph_idx == port_two_pkg::IDX_OPEN_DRAIN_SELECT) od <= wd;
            if (ph_wr && ph_idx == port_two_pkg::IDX_DATA_LATCH) lat <= wd;
            if (ph_wr && ph_idx == port_two_pkg::IDX_DIRECTION) dir <= wd;
        end
    end
    // Pad drive lags the registers by one edge
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_dir_read_ones:
    assert property (rd_dir |=> hrdata == 32'h000000FF) else $error("direction read not ones");
    a_func_read_fixed:
    assert property (rd_fs |=> hrdata == {24'h000000, fs}) else $error("function select read");
    a_latch_out_bits:
    assert property (rd_lat |=> (hrdata[7:0] & dir) == (lat & dir)) else $error("latch readback");
    a_reset_no_drive:
    assert property ($rose(rst_n) |-> pad_out.oe == 8'h00) else $error("drive after reset");
    a_hi_oe_follow:
    assert property (pad_out.oe[7:3] == $past(dir[7:3] & ~(od[7:3] & lat[7:3])))
        else $error("upper pin enable");
    a_hi_level_follow:
    assert property (pad_out.level[7:3] == $past(lat[7:3] & ~od[7:3])) else $error("upper level");
    a_so_pin_drive:
    assert property ($past(fs[2]) |-> pad_out.oe[2] == $past(~(fs[5] & serial_drive.data_out))
        && pad_out.level[2] == $past(serial_drive.data_out & ~fs[5])) else $error("serial out pin");
    a_si_pin_quiet:
    assert property ($past(fs[1]) |-> !pad_out.oe[1]) else $error("serial in pin driven");
    a_sck_pin_drive:
    assert property ($past(fs[0]) |-> pad_out.oe[0] == $past(serial_drive.clock_oe)
        && pad_out.level[0] == $past(serial_drive.clock_out)) else $error("serial clock pin");
endmodule : port_two_gpio_sva
bind port_two_gpio port_two_gpio_sva i_sva (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .pad_out, .serial_drive);
`default_nettype wire

/* File: port_two_pkg.sv */
// Package: register map, field layout and carriers for the port-two GPIO block
package port_two_pkg;

    // Pin count and bus widths
    localparam int PIN_COUNT = 8;
    localparam int BUS_WIDTH = 32;

    // Register indices; byte address is four times the index
    localparam logic [29:0] IDX_FUNCTION_SELECT = 30'h0000FFC9;
    localparam logic [29:0] IDX_OPEN_DRAIN_SELECT = 30'h0000FFCB;
    localparam logic [29:0] IDX_DATA_LATCH = 30'h0000FFD5;
    localparam logic [29:0] IDX_DIRECTION = 30'h0000FFE5;

    // Reset values
    localparam logic [7:0] RST_FUNCTION_SELECT = 8'hD8;
    localparam logic [7:0] RST_OPEN_DRAIN_SELECT = 8'h00;
    localparam logic [7:0] RST_DATA_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;

    // Function select layout
    localparam logic [7:0] FUNC_RESERVED_ONES = 8'hD8;
    localparam logic [7:0] FUNC_WRITABLE = 8'h27;
    localparam int BIT_SERIAL_OUT_PMOS_OFF = 5;
    localparam int BIT_SERIAL_OUT_PIN_SELECT = 2;
    localparam int BIT_SERIAL_IN_PIN_SELECT = 1;
    localparam int BIT_SERIAL_CLOCK_PIN_SELECT = 0;

    // Pin positions of the shared functions
    localparam int PIN_SERIAL_OUT = 2;
    localparam int PIN_SERIAL_IN = 1;
    localparam int PIN_SERIAL_CLOCK = 0;

    // Write-only direction register reads as this
    localparam logic [7:0] DIRECTION_READ_VALUE = 8'hFF;

    // AHB transfer and response codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

    // Captured AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [29:0] word;
    } addr_phase_t;

    // Drive of the eight pads
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe;
    } pad_drive_t;

    // Signals from the serial interface toward the pads
    typedef struct packed {
        logic data_out;
        logic clock_out;
        logic clock_oe;
    } serial_drive_t;

    // Signals from the pads toward the serial interface
    typedef struct packed {
        logic data_in;
        logic clock_in;
    } serial_sense_t;

endpackage : port_two_pkg

/* File: testbench.sv */
// Testbench for the port-two GPIO block with a board model
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd32;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] pad_in, ext_level, ext_oe, fsw, od, lat, dir;
    port_two_pkg::pad_drive_t pad_out;
    port_two_pkg::serial_drive_t serial_drive;
    port_two_pkg::serial_sense_t serial_sense;
    int bad_count, cmp_count;
    // One slave, so its ready is the bus ready
    assign hready = hreadyout;
    port_two_gpio i_port_two_gpio (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hrdata, .hresp, .pad_in, .pad_out, .serial_drive,
        .serial_sense);
    pad_board i_pad_board (.pad_out, .ext_level, .ext_oe, .pad_in);
    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard, far past the under one thousand cycles needed
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        close_out();
    end
    // Single word transfer; read data lands in rd32
    task ahb(input logic wr, input logic [29:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= port_two_pkg::HTRANS_NONSEQ;
        haddr <= {idx, 2'h0};
        hwrite <= wr;
        // Address phase holds until ready is seen high at a rising edge
        do begin
            @(posedge clk_sys);
        end while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        // Read data is taken at the edge that ends the data phase
        do begin
            @(posedge clk_sys);
            rd32 = hrdata;
        end while (hready !== 1'b1);
    endtask : ahb
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task close_out();
        $display("Checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Expected pad drive as {level where driven, enable}
    function automatic logic [15:0] exp_pad(input logic [7:0] f, o, l, d);
        logic [7:0] lv, oe;
        lv = l & ~o;
        oe = d & ~(o & l);
        if (f[2]) begin
            lv[2] = serial_drive.data_out & ~f[5];
            oe[2] = ~(f[5] & serial_drive.data_out);
        end
        if (f[1]) oe[1] = 1'b0;
        if (f[0]) begin
            lv[0] = serial_drive.clock_out;
            oe[0] = serial_drive.clock_oe;
        end
        return {lv & oe, oe};
    endfunction : exp_pad
    // Reset values, then random modes with every select combination first
    initial begin
        {bad_count, cmp_count} = 64'h0;
        {rst_n, hsel, hwrite, haddr, htrans, hwdata} = 69'h0;
        hsize = 3'h2;
        {ext_level, ext_oe, serial_drive} = 19'h0;
        void'($urandom(21));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        ahb(1'b0, port_two_pkg::IDX_FUNCTION_SELECT, 8'h00);
        check(rd32, 32'h000000D8);
        ahb(1'b0, port_two_pkg::IDX_OPEN_DRAIN_SELECT, 8'h00);
        check(rd32, 32'h00000000);
        check({24'h000000, pad_out.oe}, 32'h00000000);
        ahb(1'b1, port_two_pkg::IDX_DIRECTION, 8'hFF);
        ahb(1'b0, port_two_pkg::IDX_DATA_LATCH, 8'h00);
        check(rd32, 32'h00000000);
        ahb(1'b0, 30'h0000FFCA, 8'h00);
        check(rd32, 32'h00000000);
        check({31'h0, hresp}, 32'h00000000);
        for (int i = 0; i < 40; i++) begin
            fsw = (i < 16) ? {2'h0, i[3], 2'h0, i[2:0]} : 8'($urandom);
            {od, lat, dir} = 24'($urandom);
            ext_level <= 8'($urandom);
            ext_oe <= ~dir;
            serial_drive <= 3'($urandom);
            ahb(1'b1, port_two_pkg::IDX_FUNCTION_SELECT, fsw);
            ahb(1'b1, port_two_pkg::IDX_OPEN_DRAIN_SELECT, od);
            ahb(1'b1, port_two_pkg::IDX_DATA_LATCH, lat);
            ahb(1'b1, port_two_pkg::IDX_DIRECTION, dir);
            ahb(1'b0, port_two_pkg::IDX_FUNCTION_SELECT, 8'h00);
            check(rd32, {24'h000000, (fsw & 8'h27) | 8'hD8});
            ahb(1'b0, port_two_pkg::IDX_DIRECTION, 8'h00);
            check(rd32, 32'h000000FF);
            ahb(1'b0, port_two_pkg::IDX_DATA_LATCH, 8'h00);
            check(rd32, {24'h000000, (lat & dir) | (pad_in & ~dir)});
            check({16'h0, pad_out.level & pad_out.oe, pad_out.oe}, {16'h0, exp_pad(fsw, od, lat, dir)});
            check({31'h0, serial_sense.data_in}, {31'h0, fsw[1] & pad_in[1]});
            check({31'h0, serial_sense.clock_in}, {31'h0, fsw[0] & pad_in[0]});
        end
        // Second reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        ahb(1'b0, port_two_pkg::IDX_FUNCTION_SELECT, 8'h00);
        check(rd32, 32'h000000D8);
        check({24'h000000, pad_out.oe}, 32'h00000000);
        ahb(1'b0, port_two_pkg::IDX_OPEN_DRAIN_SELECT, 8'h00);
        check(rd32, 32'h00000000);
        ahb(1'b1, port_two_pkg::IDX_DIRECTION, 8'hFF);
        ahb(1'b0, port_two_pkg::IDX_DATA_LATCH, 8'h00);
        check(rd32, 32'h00000000);
        close_out();
    end
endmodule : testbench
`default_nettype wire
